// [src/hmrc_pkg.sv]
package hmrc_pkg;
    // register byte offsets on the axi4-lite port
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GPIO = 8'h04;
    localparam logic [7:0] ADDR_WAKE = 8'h08;
    localparam logic [7:0] ADDR_MODE = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    // control register fields
    localparam int CTRL_MEAS_BIT = 0;
    localparam int CTRL_FOTEST_BIT = 1;
    // gpio_config fields: mode in [1:0], output level in bit 2
    localparam logic [1:0] GPIO_OFF = 2'h0;
    localparam logic [1:0] GPIO_FAIL = 2'h1;
    localparam logic [1:0] GPIO_OUT = 2'h2;
    localparam logic [1:0] GPIO_WAKE = 2'h3;
    localparam int GPIO_LVL_BIT = 2;
    // wake configuration fields
    localparam int WAKE_INPUT_ENABLE_BIT = 0;
    localparam int WK_PU_BIT = 1;
    localparam int WK_PD_BIT = 2;
    localparam int WK_TMR_BIT = 3;
    // status / mask fields, levels are read only
    localparam int ERR_BIT = 0;
    localparam int WKA_BIT = 1;
    localparam int WKB_BIT = 2;
    localparam int LVL_BIT = 8;
    // mode command codes
    localparam logic [1:0] CMD_SLEEP = 2'h1;
    // reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [3:0] WAKE_RST = 4'h0;
    localparam logic [2:0] STAT_RST = 3'h0;
    // restart dwell time
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESTART_NS = 10000;
    localparam int RESTART_CYC = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 10;
    localparam int SYNC_W = 3;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_NORMAL, ST_SLEEP, ST_RESTART, ST_FAILSAFE} hmrc_state_e;
endpackage

// [src/hmrc_sync.sv]
`timescale 1ns/1ps
module hmrc_sync (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [hmrc_pkg::SYNC_W-1:0] async_in, // pins from outside
    output logic [hmrc_pkg::SYNC_W-1:0] sync_out // two-flop synchronised copy
);
    logic [hmrc_pkg::SYNC_W-1:0] meta_r;
    logic [hmrc_pkg::SYNC_W-1:0] sync_r;

    // per bit two flops; meta_r feeds only the second stage
    genvar gi;
    for (gi = 0; gi < hmrc_pkg::SYNC_W; gi++) begin : g_bit
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                meta_r[gi] <= 1'b0;
                sync_r[gi] <= 1'b0;
            end else begin
                meta_r[gi] <= async_in[gi];
                sync_r[gi] <= meta_r[gi];
            end
        end
    end

    assign sync_out = sync_r;
endmodule

// [src/hmrc_wake_det.sv]
`timescale 1ns/1ps
module hmrc_wake_det (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [1:0] pin_lvl, // synced sense (0) and gpio (1) levels
    input wire logic gate, // measurement path enabled: gate pin signals
    output logic [1:0] wake_ev, // one-cycle pulse on any edge
    output logic [1:0] level // last level seen while ungated
);
    logic [1:0] lvl_r;
    logic [1:0] lvl_nxt;
    logic [1:0] ev_r;
    logic [1:0] ev_nxt;

    // gated pins frozen; gating freezes the level and kills events
    genvar gi;
    for (gi = 0; gi < 2; gi++) begin : g_ch
        always_comb begin
            lvl_nxt[gi] = gate ? lvl_r[gi] : pin_lvl[gi];
            ev_nxt[gi] = !gate && (pin_lvl[gi] != lvl_r[gi]);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lvl_r <= 2'h0;
            ev_r <= 2'h0;
        end else begin
            lvl_r <= lvl_nxt;
            ev_r <= ev_nxt;
        end
    end

    assign wake_ev = ev_r;
    assign level = lvl_r;

    level_track_a: assert property (@(posedge clk) disable iff (!rst_b)
        !gate |=> level == $past(pin_lvl)) else $error("level not tracking pin");
    gate_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
        gate |=> wake_ev == 2'h0 && $stable(level)) else $error("event while gated");
endmodule

// [src/hmrc_top.sv]
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
// Contract
// - reset leaves measurement path disabled
// - enable plus normal state closes switch
// - other states open switch, enable kept
// - enabled path: pulls off, pin signals gated
// - pin settings ignored but writes stored
// - wake and level status frozen
// - pin-only wake sleep: error, restart
// - fail output, gpio, wake unavailable
// - gpio config change while enabled errors
// - enable refused unless gpio off
// - wake enables writable but ignored
// - failsafe keeps enable, switch open
// - failsafe entered without path enables sense wake
// - disabled path: normal wake and levels
// - routing only in normal state
module hmrc_top (
    input wire logic clk, // 100 mhz system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte enables
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic hv_sense_in, // hv sense input comparator level
    input wire logic fail_gpio_in, // fail/gpio pin input level
    input wire logic fail_event, // supervisor requests failsafe, async
    output logic meas_switch, // routing switch closed when high
    output logic sense_pull_up, // sense pin pull-up current on
    output logic sense_pull_dn, // sense pin pull-down current on
    output logic gpio_pull_dn, // fail/gpio pin pull-down on
    output logic fail_gpio_out, // fail/gpio pin drive level
    output logic fail_gpio_oe, // fail/gpio pin driven when high
    output logic [1:0] op_state, // current operating state
    output logic irq // level interrupt
);
    // bus state
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [7:0] wa_r, wa_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic wstb_r, wstb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wr_fire, ar_fire, wr_hit;
    // block state
    logic [2:0] ctrl_r, ctrl_nxt;
    logic [2:0] gpio_r, gpio_nxt;
    logic [3:0] wake_r, wake_nxt;
    logic [2:0] stat_r, stat_nxt, mask_r, mask_nxt, stat_set, stat_clr;
    logic fs_sense_r, fs_sense_nxt;
    logic [hmrc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    hmrc_pkg::hmrc_state_e st_r, st_nxt;
    logic [hmrc_pkg::SYNC_W-1:0] pins_s;
    logic [1:0] wake_ev, level;
    logic meas_r, sleep_cmd, sleep_bad, ctrl_wr, gpio_wr, wake_wr;
    logic sense_wk_eff, gpio_wake_mode_eff, wake_any, meas_refused, gpio_changed;

    // pins enter through two flops
    hmrc_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({fail_event, fail_gpio_in, hv_sense_in}),
        .sync_out(pins_s)
    );

    hmrc_wake_det u_det (
        .clk(clk),
        .rst_b(rst_b),
        .pin_lvl(pins_s[1:0]),
        .gate(meas_r),
        .wake_ev(wake_ev),
        .level(level)
    );

    assign meas_r = ctrl_r[hmrc_pkg::CTRL_MEAS_BIT];

    // axi4-lite handshakes; address and data may come in either order
    assign awready = !aw_full_r && !bvalid_r;
    assign wready = !w_full_r && !bvalid_r;
    assign arready = !rvalid_r;
    assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
    assign ar_fire = arvalid && arready;
    assign wr_hit = wa_r == hmrc_pkg::ADDR_CTRL || wa_r == hmrc_pkg::ADDR_GPIO ||
        wa_r == hmrc_pkg::ADDR_WAKE || wa_r == hmrc_pkg::ADDR_MODE ||
        wa_r == hmrc_pkg::ADDR_STAT || wa_r == hmrc_pkg::ADDR_MASK;

    // bus next state and read decode
    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        wa_nxt = wa_r;
        wd_nxt = wd_r;
        wstb_nxt = wstb_r;
        bvalid_nxt = bvalid_r && !bready;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (awvalid && awready) begin
            aw_full_nxt = 1'b1;
            wa_nxt = awaddr;
        end
        if (wvalid && wready) begin
            w_full_nxt = 1'b1;
            wd_nxt = wdata;
            wstb_nxt = wstrb[0];
        end
        if (wr_fire) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_hit ? hmrc_pkg::RESP_OKAY : hmrc_pkg::RESP_SLVERR;
        end
        if (ar_fire) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = hmrc_pkg::RESP_OKAY;
            rdata_nxt = 32'h0;
            unique case (araddr)
                hmrc_pkg::ADDR_CTRL: rdata_nxt[2:0] = ctrl_r;
                hmrc_pkg::ADDR_GPIO: rdata_nxt[2:0] = gpio_r;
                hmrc_pkg::ADDR_WAKE: rdata_nxt[3:0] = wake_r;
                hmrc_pkg::ADDR_MODE: rdata_nxt[1:0] = st_r;
                hmrc_pkg::ADDR_STAT: begin
                    rdata_nxt[2:0] = stat_r;
                    rdata_nxt[hmrc_pkg::LVL_BIT +: 2] = level;
                end
                hmrc_pkg::ADDR_MASK: rdata_nxt[2:0] = mask_r;
                default: rresp_nxt = hmrc_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            wa_r <= 8'h0;
            wd_r <= 32'h0;
            wstb_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            wa_r <= wa_nxt;
            wd_r <= wd_nxt;
            wstb_r <= wstb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // register write strobes; every writable field sits in byte lane 0
    assign ctrl_wr = wr_fire && wstb_r && wa_r == hmrc_pkg::ADDR_CTRL;
    assign gpio_wr = wr_fire && wstb_r && wa_r == hmrc_pkg::ADDR_GPIO;
    assign wake_wr = wr_fire && wstb_r && wa_r == hmrc_pkg::ADDR_WAKE;
    assign sleep_cmd = wr_fire && wstb_r && wa_r == hmrc_pkg::ADDR_MODE &&
        wd_r[1:0] == hmrc_pkg::CMD_SLEEP;
    assign meas_refused = ctrl_wr && wd_r[hmrc_pkg::CTRL_MEAS_BIT] && !meas_r &&
        gpio_r[1:0] != hmrc_pkg::GPIO_OFF;
    assign gpio_changed = gpio_wr && meas_r && wd_r[2:0] != gpio_r;
    assign sense_wk_eff = !meas_r && (wake_r[hmrc_pkg::WAKE_INPUT_ENABLE_BIT] || fs_sense_r);
    assign gpio_wake_mode_eff = !meas_r && gpio_r[1:0] == hmrc_pkg::GPIO_WAKE;
    assign sleep_bad = meas_r && !wake_r[hmrc_pkg::WK_TMR_BIT];
    assign stat_set = {wake_ev[1] && gpio_wake_mode_eff, wake_ev[0] && sense_wk_eff,
        meas_refused || gpio_changed || (sleep_cmd && sleep_bad && st_r == hmrc_pkg::ST_NORMAL)};
    assign stat_clr = (wr_fire && wstb_r && wa_r == hmrc_pkg::ADDR_STAT) ? wd_r[2:0] : 3'h0;
    assign wake_any = |stat_set[2:1];

    // registers and operating state machine
    always_comb begin
        ctrl_nxt = ctrl_r;
        gpio_nxt = gpio_r;
        wake_nxt = wake_r;
        mask_nxt = mask_r;
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        fs_sense_nxt = fs_sense_r;
        stat_nxt = (stat_r & ~stat_clr) | stat_set;
        if (ctrl_wr) begin
            ctrl_nxt = wd_r[2:0];
            if (meas_refused) begin
                ctrl_nxt[hmrc_pkg::CTRL_MEAS_BIT] = 1'b0;
            end
        end
        if (gpio_wr) begin
            gpio_nxt = wd_r[2:0];
        end
        if (wake_wr) begin
            wake_nxt = wd_r[3:0];
        end
        if (wr_fire && wstb_r && wa_r == hmrc_pkg::ADDR_MASK) begin
            mask_nxt = wd_r[2:0];
        end
        unique case (st_r)
            hmrc_pkg::ST_NORMAL: begin
                if (pins_s[2]) begin
                    st_nxt = hmrc_pkg::ST_FAILSAFE;
                end else if (sleep_cmd) begin
                    st_nxt = sleep_bad ? hmrc_pkg::ST_RESTART : hmrc_pkg::ST_SLEEP;
                    cnt_nxt = '0;
                end
            end
            hmrc_pkg::ST_SLEEP: begin
                if (pins_s[2]) begin
                    st_nxt = hmrc_pkg::ST_FAILSAFE;
                end else if (wake_any) begin
                    st_nxt = hmrc_pkg::ST_RESTART;
                    cnt_nxt = '0;
                end
            end
            hmrc_pkg::ST_RESTART: begin
                if (pins_s[2]) begin
                    st_nxt = hmrc_pkg::ST_FAILSAFE;
                end else if (cnt_r == hmrc_pkg::CNT_W'(hmrc_pkg::RESTART_CYC - 1)) begin
                    st_nxt = hmrc_pkg::ST_NORMAL;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            hmrc_pkg::ST_FAILSAFE: begin
                if (!pins_s[2] && wake_any) begin
                    st_nxt = hmrc_pkg::ST_RESTART;
                    cnt_nxt = '0;
                end
            end
        endcase
        if (st_nxt == hmrc_pkg::ST_FAILSAFE && st_r != hmrc_pkg::ST_FAILSAFE) begin
            fs_sense_nxt = !ctrl_nxt[hmrc_pkg::CTRL_MEAS_BIT];
        end else if (st_nxt != hmrc_pkg::ST_FAILSAFE) begin
            fs_sense_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= hmrc_pkg::CTRL_RST;
            gpio_r <= 3'h0;
            wake_r <= hmrc_pkg::WAKE_RST;
            stat_r <= hmrc_pkg::STAT_RST;
            mask_r <= 3'h0;
            st_r <= hmrc_pkg::ST_NORMAL;
            cnt_r <= '0;
            fs_sense_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            gpio_r <= gpio_nxt;
            wake_r <= wake_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            fs_sense_r <= fs_sense_nxt;
        end
    end

    assign meas_switch = meas_r && st_r == hmrc_pkg::ST_NORMAL;
    assign sense_pull_up = !meas_r && wake_r[hmrc_pkg::WK_PU_BIT];
    assign sense_pull_dn = !meas_r && wake_r[hmrc_pkg::WK_PD_BIT];
    assign gpio_pull_dn = gpio_wake_mode_eff;
    // fail output and gpio disabled; fail output drives low
    assign fail_gpio_oe = !meas_r && (gpio_r[1:0] == hmrc_pkg::GPIO_OUT ||
        (gpio_r[1:0] == hmrc_pkg::GPIO_FAIL &&
        (st_r == hmrc_pkg::ST_FAILSAFE || ctrl_r[hmrc_pkg::CTRL_FOTEST_BIT])));
    assign fail_gpio_out = !meas_r && gpio_r[1:0] == hmrc_pkg::GPIO_OUT &&
        gpio_r[hmrc_pkg::GPIO_LVL_BIT];
    assign op_state = st_r;
    assign irq = |(stat_r & mask_r);
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    reset_open_a: assert property ($rose(rst_b) |-> !meas_switch && !fail_gpio_oe)
        else $error("path active after reset");
    switch_close_a: assert property (ctrl_wr && wd_r[0] && !meas_r &&
        gpio_r[1:0] == hmrc_pkg::GPIO_OFF && st_r == hmrc_pkg::ST_NORMAL && !pins_s[2]
        && !sleep_cmd |=> meas_switch) else $error("switch did not close");
    switch_open_a: assert property (st_r != hmrc_pkg::ST_NORMAL |-> !meas_switch)
        else $error("switch closed outside normal");
    cfg_kept_a: assert property (meas_r && !ctrl_wr |=> meas_r)
        else $error("measurement config lost");
    pulls_off_a: assert property (meas_r |-> !sense_pull_up && !sense_pull_dn
        && !gpio_pull_dn) else $error("pull active while routing");
    wake_store_a: assert property (wake_wr |=> wake_r == $past(wd_r[3:0]))
        else $error("wake config not stored");
    stat_frozen_a: assert property (meas_r && stat_clr[2:1] == 2'h0 |=>
        stat_r[2:1] == $past(stat_r[2:1])) else $error("wake flag set while routing");
    sleep_refuse_a: assert property (sleep_cmd && sleep_bad &&
        st_r == hmrc_pkg::ST_NORMAL && !pins_s[2] |=> st_r == hmrc_pkg::ST_RESTART
        && stat_r[0]) else $error("bad sleep not refused");
    fo_off_a: assert property (meas_r |-> !fail_gpio_oe)
        else $error("pin driven while routing");
    gpio_err_a: assert property (gpio_changed |=> stat_r[0])
        else $error("gpio change not flagged");
    meas_refuse_a: assert property (meas_refused |=> !meas_r && stat_r[0])
        else $error("enable not refused");
    wake_ignored_a: assert property (meas_r |-> !sense_wk_eff && !gpio_wake_mode_eff)
        else $error("wake enable honoured while routing");
    fs_sense_a: assert property (st_r == hmrc_pkg::ST_FAILSAFE && !meas_r
        |-> sense_wk_eff) else $error("failsafe sense wake missing");
    normal_only_a: assert property (meas_switch |-> op_state == hmrc_pkg::ST_NORMAL)
        else $error("routing outside normal");
    err_sticky_a: assert property (stat_r[0] && !stat_clr[0] |=> stat_r[0])
        else $error("error flag lost");

    refuse_c: cover property (meas_refused ##1 stat_r[0]);
    route_c: cover property (meas_switch ##1 !meas_switch ##[1:1000] meas_switch);
    failsafe_c: cover property (st_r == hmrc_pkg::ST_FAILSAFE && meas_r);
    bad_sleep_c: cover property (sleep_cmd && sleep_bad);
endmodule

// [sim/hmrc_host.sv]
`timescale 1ns/1ps
// microcontroller side of the register bus, one transfer at a time
module hmrc_host (
    input wire logic clk, // clock
    output logic [7:0] awaddr, // aw addr
    output logic awvalid, // aw valid
    input wire logic awready, // aw ready
    output logic [31:0] wdata, // w data
    output logic [3:0] wstrb, // w strobes
    output logic wvalid, // w valid
    input wire logic wready, // w ready
    input wire logic [1:0] bresp, // b resp
    input wire logic bvalid, // b valid
    output logic bready, // b ready
    output logic [7:0] araddr, // ar addr
    output logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic [31:0] rdata, // r data
    input wire logic rvalid, // r valid
    output logic rready // r ready
);
    // idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // bready stays up, so the response is taken at the edge it is seen
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    // read: data taken at the edge where rvalid is sampled
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
    endtask
endmodule

// [sim/hmrc_top_tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin #1; n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end @(posedge clk); end
module hmrc_top_tb_top;
    logic clk, rst_b, hv_sense_in, fail_gpio_in, fail_event, meas_switch, irq;
    logic sense_pull_up, sense_pull_dn, gpio_pull_dn, fail_gpio_out, fail_gpio_oe;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, op_state, r;
    int n_fail = 0;
    int n_compared = 0;

    hmrc_host i_hmrc_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready));
    hmrc_top i_hmrc_top (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .hv_sense_in(hv_sense_in), .fail_gpio_in(fail_gpio_in), .fail_event(fail_event),
        .meas_switch(meas_switch), .sense_pull_up(sense_pull_up),
        .sense_pull_dn(sense_pull_dn), .gpio_pull_dn(gpio_pull_dn),
        .fail_gpio_out(fail_gpio_out), .fail_gpio_oe(fail_gpio_oe), .op_state(op_state),
        .irq(irq));

    // 100 mhz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_hmrc_host.wr(a, v, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        i_hmrc_host.rd(a, d);
        `CHK({rresp, d}, {hmrc_pkg::RESP_OKAY, e})
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // the restart dwell dominates the run, so a generous cap still catches hangs
    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end

    initial begin
        {rst_b, hv_sense_in, fail_gpio_in, fail_event} = '0;
        hold(20);
        rst_b <= 1'b1;
        `CHK(meas_switch, 1'b0)
        rdc(hmrc_pkg::ADDR_CTRL, 32'h0);
        wr(8'h40, 32'h1);
        `CHK(r, hmrc_pkg::RESP_SLVERR)
        i_hmrc_host.rd(8'h40, d);
        `CHK({rresp, d}, {hmrc_pkg::RESP_SLVERR, 32'h0})
        $display("test reset and bus done");
        // enable refused while the pin is a fail output
        wr(hmrc_pkg::ADDR_MASK, 32'h1);
        wr(hmrc_pkg::ADDR_GPIO, 32'h1);
        wr(hmrc_pkg::ADDR_CTRL, 32'h1);
        rdc(hmrc_pkg::ADDR_CTRL, 32'h0);
        rdc(hmrc_pkg::ADDR_STAT, 32'h1);
        `CHK(irq, 1'b1)
        wr(hmrc_pkg::ADDR_MASK, 32'h0);
        `CHK(irq, 1'b0)
        wr(hmrc_pkg::ADDR_MASK, 32'h1);
        rdc(hmrc_pkg::ADDR_STAT, 32'h1);
        wr(hmrc_pkg::ADDR_STAT, 32'h1);
        `CHK(irq, 1'b0)
        $display("test refused enable done");
        // pin set off first, then the path may be enabled
        wr(hmrc_pkg::ADDR_GPIO, 32'h0);
        wr(hmrc_pkg::ADDR_CTRL, 32'h3);
        rdc(hmrc_pkg::ADDR_CTRL, 32'h3);
        `CHK(meas_switch, 1'b1)
        wr(hmrc_pkg::ADDR_WAKE, 32'h7);
        rdc(hmrc_pkg::ADDR_WAKE, 32'h7);
        `CHK({sense_pull_up, sense_pull_dn, fail_gpio_oe}, 3'h0)
        wr(hmrc_pkg::ADDR_GPIO, 32'h3);
        rdc(hmrc_pkg::ADDR_GPIO, 32'h3);
        rdc(hmrc_pkg::ADDR_STAT, 32'h1);
        `CHK(gpio_pull_dn, 1'b0)
        wr(hmrc_pkg::ADDR_STAT, 32'h7);
        // rewriting the same value is no change
        wr(hmrc_pkg::ADDR_GPIO, 32'h3);
        rdc(hmrc_pkg::ADDR_STAT, 32'h0);
        wr(hmrc_pkg::ADDR_GPIO, 32'h6);
        `CHK({fail_gpio_out, fail_gpio_oe}, 2'h0)
        wr(hmrc_pkg::ADDR_STAT, 32'h7);
        hv_sense_in <= 1'b1;
        fail_gpio_in <= 1'b1;
        hold(8);
        rdc(hmrc_pkg::ADDR_STAT, 32'h0);
        $display("test enabled path done");
        // only pin wake sources while enabled: sleep is turned into restart
        wr(hmrc_pkg::ADDR_MODE, {30'h0, hmrc_pkg::CMD_SLEEP});
        `CHK(op_state, hmrc_pkg::ST_RESTART)
        `CHK(meas_switch, 1'b0)
        rdc(hmrc_pkg::ADDR_STAT, 32'h1);
        for (int i = 0; i < 1100 && op_state !== hmrc_pkg::ST_NORMAL; i++) hold(1);
        `CHK(meas_switch, 1'b1)
        $display("test sleep refused done");
        fail_event <= 1'b1;
        hold(5);
        `CHK(op_state, hmrc_pkg::ST_FAILSAFE)
        `CHK(meas_switch, 1'b0)
        rdc(hmrc_pkg::ADDR_CTRL, 32'h3);
        $display("test failsafe enabled done");
        // second reset in mid-run with pins low, so no edge at release
        rst_b <= 1'b0;
        {hv_sense_in, fail_gpio_in, fail_event} <= '0;
        hold(3);
        rst_b <= 1'b1;
        `CHK(meas_switch, 1'b0)
        wr(hmrc_pkg::ADDR_GPIO, 32'h6);
        `CHK({fail_gpio_out, fail_gpio_oe}, 2'h3)
        wr(hmrc_pkg::ADDR_GPIO, 32'h3);
        wr(hmrc_pkg::ADDR_WAKE, 32'h7);
        `CHK({sense_pull_up, sense_pull_dn, gpio_pull_dn}, 3'h7)
        wr(hmrc_pkg::ADDR_STAT, 32'h7);
        hv_sense_in <= 1'b1;
        fail_gpio_in <= 1'b1;
        hold(8);
        rdc(hmrc_pkg::ADDR_STAT, 32'h306);
        $display("test normal wake done");
        // no sense wake source set: failsafe must arm the sense input by itself
        wr(hmrc_pkg::ADDR_WAKE, 32'h0);
        wr(hmrc_pkg::ADDR_STAT, 32'h7);
        fail_event <= 1'b1;
        hold(5);
        `CHK(op_state, hmrc_pkg::ST_FAILSAFE)
        fail_event <= 1'b0;
        hold(5);
        hv_sense_in <= 1'b0;
        hold(8);
        `CHK(op_state, hmrc_pkg::ST_RESTART)
        $display("test failsafe wake done");
        // path off: sleep is taken, a gpio pin edge wakes the block
        for (int i = 0; i < 1100 && op_state !== hmrc_pkg::ST_NORMAL; i++) hold(1);
        wr(hmrc_pkg::ADDR_MODE, {30'h0, hmrc_pkg::CMD_SLEEP});
        `CHK(op_state, hmrc_pkg::ST_SLEEP)
        fail_gpio_in <= 1'b0;
        hold(8);
        `CHK(op_state, hmrc_pkg::ST_RESTART)
        $display("test sleep wake done");
        end_of_test();
    end
endmodule
